// >>> emh_dec_if.sv
// interface between the top and its port address decoder
`timescale 1ns/1ps
`default_nettype none
interface emh_dec_if;
	logic [15:0] ioAddr;
	logic        remap;
	logic [15:0] canon;
	logic        enhHit;
	logic        setupHit;
	logic        crtcIxHit;
	logic        crtcDatHit;
	modport dec (input ioAddr, remap, output canon, enhHit, setupHit, crtcIxHit, crtcDatHit);
	modport top (output ioAddr, remap, input canon, enhHit, setupHit, crtcIxHit, crtcDatHit);
endinterface
`default_nettype wire

// >>> emh_decode.sv
// enhanced mode host decode: ports, mode bits and memory steering
`timescale 1ns/1ps
`default_nettype none
module emh_decode #(
	parameter int MEM_AW  = 22, // display memory address width
	parameter int INT_SRC = 4   // interrupt sources
) (
	input  wire logic                         clk,         // bus clock
	input  wire logic                         resetn,      // async reset, low
	input  wire logic                         ioWr,        // port write
	input  wire logic                         ioRd,        // port read
	input  wire logic [emh_pkg::IO_AW-1:0]    ioAddr,      // port address
	input  wire logic [15:0]                  ioWdata,     // port write data
	input  wire logic                         memWr,       // memory write
	input  wire logic                         memRd,       // memory read
	input  wire logic [emh_pkg::HA_W-1:0]     memAddr,     // host memory address
	input  wire logic [15:0]                  memWdata,    // memory write data
	input  wire logic                         engineBusy,  // drawing engine busy
	input  wire logic [15:0]                  engineRdata, // engine read data
	input  wire logic                         dacWrReq,    // palette write request
	input  wire logic [7:0]                   dacWrIdx,    // palette entry
	output logic                              rdValid,     // read answer
	output logic [15:0]                       rdData,      // read data
	output logic                              enhWr,       // command write
	output logic                              enhRd,       // engine read
	output logic [15:0]                       enhAddr,     // canonical port
	output logic [15:0]                       enhData,     // command data
	output logic                              enhMem,      // came by memory
	output logic                              dispWr,      // display write
	output logic                              dispRd,      // display read
	output logic [MEM_AW-1:0]                 dispAddr,    // display address
	output logic [15:0]                       dispData,    // display data
	output logic                              dispVgaMap,  // VGA mapping applies
	output logic                              wrPosted,    // write is posted
	output logic                              advFuncEn,   // advanced display on
	output logic                              cursorEn,    // cursor shown
	output logic                              cursorExt,   // external cursor
	output logic                              crtTranslate,// legacy emulation
	output logic                              dacWrGrant,  // palette write allowed
	output logic [INT_SRC-1:0]                intEnable,   // interrupt enables
	output logic                              subsysEn     // video subsystem on
);
	import emh_pkg::*;

	if (MEM_AW < 18 || MEM_AW > 22) begin : g_chkAw
		$error("MEM_AW must lie between 18 and 22");
	end
	if (INT_SRC < 1 || INT_SRC > 8) begin : g_chkInt
		$error("INT_SRC must lie between 1 and 8");
	end

	typedef struct packed {
		logic [7:0]         crtcIx;
		logic [7:0]         lock1;
		logic [7:0]         lock2;
		logic [7:0]         memCfg;
		logic [7:0]         compat1;
		logic [7:0]         compat2;
		logic [7:0]         crtLock;
		logic [7:0]         misc1;
		logic [7:0]         sysCfg;
		logic [7:0]         extMode;
		logic [7:0]         curMode;
		logic [7:0]         extSys2;
		logic [7:0]         extMem;
		logic [7:0]         dacCtl;
		logic [7:0]         linCtl;
		logic [7:0]         linPosH;
		logic [7:0]         linPosL;
		logic [7:0]         setup;
		logic [15:0]        afc;
		logic [INT_SRC-1:0] intEna;
		logic               rdValid;
		logic [15:0]        rdData;
		logic               engPend;
		logic               enhWr;
		logic               enhRd;
		logic               enhMem;
		logic [15:0]        enhAddr;
		logic [15:0]        enhData;
		logic               dispWr;
		logic               dispRd;
		logic               dispVga;
		logic [MEM_AW-1:0]  dispAddr;
		logic [15:0]        dispData;
		logic               wrPosted;
		logic               dacGrant;
	} emh_state_t;

	emh_state_t        st;
	emh_state_t        next_st;
	emh_dec_if         dio ();
	logic              sysOpen;
	logic              vgaxOpen;
	logic              enhOpen;
	logic              mmioOn;
	logic              linOn;
	logic              pixHit;
	logic              cmdSeg;
	logic              cmdHit;
	logic              rdSelHit;
	logic              linHit;
	logic              winHit;
	logic              textHit;
	logic              regOpen;
	logic [7:0]        crtcVal;
	logic [15:0]       linPos;
	logic [21:0]       bankAddr;
	logic              claim;
	logic              claimVga;
	logic [MEM_AW-1:0] claimAddr;

	assign dio.ioAddr = ioAddr;
	assign dio.remap = st.extMode[B_REMAP];

	emh_io_decode u_dec (
		.d (dio)
	);

	// significant bits only; any other value relocks at once
	assign sysOpen = (st.lock2 & LOCK2_MASK) == LOCK2_KEY;
	assign vgaxOpen = (st.lock1 & LOCK1_MASK) == LOCK1_KEY;
	assign enhOpen = st.sysCfg[B_ENH_UNLOCK];
	// gated by the unlock, since mapped ports are still the same group
	assign mmioOn = enhOpen && (st.extMem[B_MMIO_EXT] || st.afc[B_AFC_MMIO]);
	assign linOn = st.linCtl[B_LIN_EN] || st.afc[B_AFC_LIN];
	assign linPos = {st.linPosH, st.linPosL};
	assign pixHit = memAddr[31:15] == MEM_PIX_SEG;
	assign cmdSeg = memAddr[31:15] == MEM_CMD_SEG;
	assign cmdHit = cmdSeg && memAddr[15:12] >= CMD_NIB_LO && memAddr[15:12] <= CMD_NIB_HI
		&& memAddr[7:0] == CMD_LOW;
	assign rdSelHit = memAddr[15:0] == IO_MFC && memWdata[15:12] == MFC_RDSEL;
	assign linHit = linOn && memAddr[HA_W-1:MEM_AW] == linPos[15:MEM_AW-16];
	assign winHit = memAddr[31:16] == MEM_A_SEG;
	assign textHit = memAddr[31:16] == MEM_B_SEG;
	assign bankAddr = {st.extSys2[3:2], st.crtLock[3:0], memAddr[15:0]};

	// the lock registers stay reachable so software can open the groups
	always_comb begin
		if (st.crtcIx == IX_LOCK1 || st.crtcIx == IX_LOCK2) begin
			regOpen = 1'b1;
		end else if (st.crtcIx >= IX_SYS_LO) begin
			regOpen = sysOpen;
		end else if (st.crtcIx >= IX_VGAX_LO) begin
			regOpen = vgaxOpen;
		end else begin
			regOpen = 1'b0;
		end
	end

	always_comb begin
		case (st.crtcIx)
			IX_MEMCFG:  crtcVal = st.memCfg;
			IX_COMPAT1: crtcVal = st.compat1;
			IX_COMPAT2: crtcVal = st.compat2;
			IX_CRTLOCK: crtcVal = st.crtLock;
			IX_LOCK1:   crtcVal = st.lock1;
			IX_LOCK2:   crtcVal = st.lock2;
			IX_MISC1:   crtcVal = st.misc1;
			IX_SYSCFG:  crtcVal = st.sysCfg;
			IX_EXTMODE: crtcVal = st.extMode;
			IX_CURSOR:  crtcVal = st.curMode;
			IX_EXTSYS2: crtcVal = st.extSys2;
			IX_EXTMEM:  crtcVal = st.extMem;
			IX_DACCTL:  crtcVal = st.dacCtl;
			IX_LINCTL:  crtcVal = st.linCtl;
			IX_LINPOSH: crtcVal = st.linPosH;
			IX_LINPOSL: crtcVal = st.linPosL;
			default:    crtcVal = RST_REG;
		endcase
	end

	// memory steering; mapped ports win over the linear window
	always_comb begin
		claim = 1'b0;
		claimVga = 1'b0;
		claimAddr = '0;
		if (mmioOn && (pixHit || cmdSeg)) begin
			claim = 1'b0;
		end else if (linHit) begin
			claim = 1'b1;
			claimAddr = memAddr[MEM_AW-1:0];
		end else if (textHit && st.misc1[B_TEXT]) begin
			claim = 1'b1;
			if (memAddr[B_TEXT_SEL]) begin
				claimAddr = {{(MEM_AW-16){1'b1}}, memAddr[15:0]};
			end else begin
				claimAddr = {{(MEM_AW-15){1'b1}}, memAddr[14:0]};
			end
		end else if (winHit && st.memCfg[B_WIN64]) begin
			claim = 1'b1;
			if (st.memCfg[B_BANK_ADD]) begin
				claimAddr = bankAddr[MEM_AW-1:0];
			end else begin
				claimAddr = {{(MEM_AW-16){1'b0}}, memAddr[15:0]};
			end
		end else if (winHit || textHit) begin
			claim = 1'b1;
			claimVga = 1'b1;
			claimAddr = {{(MEM_AW-17){1'b0}}, memAddr[16:0]};
		end
	end

	always_comb begin
		next_st = st;
		next_st.rdValid = 1'b0;
		next_st.engPend = 1'b0;
		next_st.enhWr = 1'b0;
		next_st.enhRd = 1'b0;
		next_st.dispWr = 1'b0;
		next_st.dispRd = 1'b0;
		next_st.wrPosted = 1'b0;
		// legacy modes only own the first 64 entries
		next_st.dacGrant = dacWrReq && !st.compat2[B_PAL_LOCK]
			&& (!st.compat1[B_LEGACY] || dacWrIdx < LEGACY_DAC);
		if (st.engPend) begin
			next_st.rdValid = 1'b1;
			next_st.rdData = engineRdata;
		end
		if (ioWr) begin
			if (dio.crtcIxHit) begin
				next_st.crtcIx = ioWdata[7:0];
			end else if (dio.crtcDatHit && regOpen) begin
				case (st.crtcIx)
					IX_MEMCFG:  next_st.memCfg = ioWdata[7:0];
					IX_COMPAT1: next_st.compat1 = ioWdata[7:0];
					IX_COMPAT2: next_st.compat2 = ioWdata[7:0];
					IX_CRTLOCK: next_st.crtLock = ioWdata[7:0];
					IX_LOCK1:   next_st.lock1 = ioWdata[7:0];
					IX_LOCK2:   next_st.lock2 = ioWdata[7:0];
					IX_MISC1:   next_st.misc1 = ioWdata[7:0];
					IX_SYSCFG:  next_st.sysCfg = ioWdata[7:0];
					IX_EXTMODE: next_st.extMode = ioWdata[7:0];
					IX_CURSOR:  next_st.curMode = ioWdata[7:0];
					IX_EXTSYS2: next_st.extSys2 = ioWdata[7:0];
					IX_EXTMEM:  next_st.extMem = ioWdata[7:0];
					IX_DACCTL:  next_st.dacCtl = ioWdata[7:0];
					IX_LINCTL:  next_st.linCtl = ioWdata[7:0];
					IX_LINPOSH: next_st.linPosH = ioWdata[7:0];
					IX_LINPOSL: next_st.linPosL = ioWdata[7:0];
					default:    next_st.crtcIx = st.crtcIx;
				endcase
			end else if (dio.setupHit) begin
				next_st.setup = ioWdata[7:0];
			end else if (dio.enhHit && enhOpen) begin
				next_st.enhWr = 1'b1;
				next_st.enhMem = 1'b0;
				next_st.enhAddr = dio.canon;
				next_st.enhData = ioWdata;
				next_st.wrPosted = 1'b1;
				if (dio.canon == IO_AFC) begin
					next_st.afc = ioWdata;
				end
				if (dio.canon == IO_SUBSYS) begin
					next_st.intEna = ioWdata[INT_ENA_LSB +: INT_SRC];
				end
			end
		end else if (ioRd) begin
			next_st.rdValid = 1'b1;
			next_st.rdData = '0;
			if (dio.crtcIxHit) begin
				next_st.rdData[7:0] = st.crtcIx;
			end else if (dio.crtcDatHit) begin
				next_st.rdData[7:0] = regOpen ? crtcVal : RST_REG;
			end else if (dio.setupHit) begin
				next_st.rdData[7:0] = st.setup;
			end else if (dio.enhHit && enhOpen && dio.canon == IO_AFC) begin
				next_st.rdData = st.afc;
			end else if (dio.enhHit && enhOpen && dio.canon == IO_STATUS) begin
				next_st.rdData[B_BUSY] = engineBusy;
			end else if (dio.enhHit && enhOpen) begin
				// engine answers one cycle after the strobe
				next_st.rdValid = 1'b0;
				next_st.enhRd = 1'b1;
				next_st.enhMem = 1'b0;
				next_st.enhAddr = dio.canon;
				next_st.engPend = 1'b1;
			end else begin
				next_st.rdValid = 1'b0;
			end
		end
		if (memWr || memRd) begin
			if (mmioOn && pixHit) begin
				next_st.enhMem = 1'b1;
				next_st.enhAddr = memAddr[1] ? IO_PIX_HI : IO_PIX_LO;
				next_st.enhData = memWdata;
				next_st.enhWr = memWr;
				next_st.wrPosted = memWr;
				next_st.enhRd = memRd;
				next_st.engPend = memRd;
			end else if (mmioOn && cmdSeg) begin
				// write only; reads and the read selector are dropped
				if (memWr && cmdHit && !rdSelHit) begin
					next_st.enhWr = 1'b1;
					next_st.enhMem = 1'b1;
					next_st.enhAddr = memAddr[15:0];
					next_st.enhData = memWdata;
					next_st.wrPosted = 1'b1;
				end
			end else if (claim) begin
				next_st.dispWr = memWr;
				next_st.dispRd = memRd;
				next_st.dispAddr = claimAddr;
				next_st.dispVga = claimVga;
				next_st.dispData = memWdata;
				next_st.wrPosted = memWr && st.sysCfg[B_POST];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdValid = st.rdValid;
	assign rdData = st.rdData;
	assign enhWr = st.enhWr;
	assign enhRd = st.enhRd;
	assign enhAddr = st.enhAddr;
	assign enhData = st.enhData;
	assign enhMem = st.enhMem;
	assign dispWr = st.dispWr;
	assign dispRd = st.dispRd;
	assign dispAddr = st.dispAddr;
	assign dispData = st.dispData;
	assign dispVgaMap = st.dispVga;
	assign wrPosted = st.wrPosted;
	assign advFuncEn = st.afc[B_AFC_EN];
	assign cursorEn = st.curMode[B_CUR_EN];
	assign cursorExt = st.dacCtl[B_CUR_EXT];
	assign crtTranslate = st.compat1[B_LEGACY];
	assign dacWrGrant = st.dacGrant;
	assign intEnable = st.intEna;
	assign subsysEn = st.setup[B_SETUP_EN];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_pixWrite;
		memWr && mmioOn && pixHit;
	endsequence
	sequence s_curWrite;
		ioWr && dio.crtcDatHit && st.crtcIx == IX_CURSOR && sysOpen;
	endsequence

	property p_enhLocked;
		enhWr && !enhMem |-> $past(st.sysCfg[B_ENH_UNLOCK]);
	endproperty
	a_enhLocked: assert property (p_enhLocked)
		else $error("port command write while group locked");
	property p_advFunc;
		$rose(advFuncEn) |-> $past(ioWr && dio.canon == IO_AFC && ioWdata[B_AFC_EN]);
	endproperty
	a_advFunc: assert property (p_advFunc)
		else $error("advanced functions enabled without control write");
	property p_remapOn;
		ioWr && st.extMode[B_REMAP] && enhOpen && ioAddr == (IO_AFC ^ IO_REMAP_XOR)
			|=> enhWr && enhAddr == IO_AFC;
	endproperty
	a_remapOn: assert property (p_remapOn)
		else $error("remapped control port not decoded");
	property p_remapOff;
		ioWr && st.extMode[B_REMAP] && ioAddr == IO_AFC |=> !enhWr;
	endproperty
	a_remapOff: assert property (p_remapOff)
		else $error("default port answered while remapped");
	property p_setupFixed;
		ioWr && ioAddr == IO_SETUP |=> !enhWr && st.setup == $past(ioWdata[7:0]);
	endproperty
	a_setupFixed: assert property (p_setupFixed)
		else $error("setup port write lost or misdecoded");
	property p_mmioPix;
		s_pixWrite |=> enhWr && enhMem && enhAddr == ($past(memAddr[1]) ? IO_PIX_HI : IO_PIX_LO);
	endproperty
	a_mmioPix: assert property (p_mmioPix)
		else $error("mapped pixel write not forwarded");
	property p_noRdSel;
		enhWr && enhMem |-> !(enhAddr == IO_MFC && enhData[15:12] == MFC_RDSEL);
	endproperty
	a_noRdSel: assert property (p_noRdSel)
		else $error("read selector reached through memory");
	property p_posted;
		enhWr |-> wrPosted;
	endproperty
	a_posted: assert property (p_posted)
		else $error("command write not posted");
	property p_cursor;
		s_curWrite |=> cursorEn == $past(ioWdata[B_CUR_EN]);
	endproperty
	a_cursor: assert property (p_cursor)
		else $error("cursor enable does not follow its bit");
	property p_palLock;
		dacWrGrant |-> !$past(st.compat2[B_PAL_LOCK]);
	endproperty
	a_palLock: assert property (p_palLock)
		else $error("palette write granted while locked");
endmodule
`default_nettype wire

// >>> emh_decode_tb.sv
// self-checking bench for the enhanced mode host decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module emh_decode_tb;
	import emh_pkg::*;
	typedef struct {logic r; logic [15:0] a; logic h; logic [15:0] c;} emh_row_t;
	logic clk, resetn, ioWr, ioRd, memWr, memRd, engineBusy, dacWrReq;
	logic [15:0] ioAddr, ioWdata, memWdata, engineRdata, rdData, enhAddr, enhData, dispData;
	logic [31:0] memAddr;
	logic [7:0]  dacWrIdx;
	logic [21:0] dispAddr;
	logic [3:0]  intEnable;
	logic rdValid, enhWr, enhRd, enhMem, dispWr, dispRd, dispVgaMap, wrPosted;
	logic advFuncEn, cursorEn, cursorExt, crtTranslate, dacWrGrant, subsysEn;
	int n_errors = 0;
	int compares = 0;
	emh_row_t rows[7] = '{
		'{1'b0, 16'h92e8, 1'b1, 16'h92e8}, '{1'b0, 16'h96e8, 1'b1, 16'h96e8},
		'{1'b0, 16'h92e9, 1'b0, 16'h0000}, '{1'b0, 16'h96f8, 1'b0, 16'h0000},
		'{1'b1, 16'h9148, 1'b1, 16'h92e8}, '{1'b1, 16'hbd48, 1'b1, 16'hbee8},
		'{1'b1, 16'h92e8, 1'b0, 16'h0000}};
	emh_decode #(.MEM_AW(22), .INT_SRC(4)) i_dut (.clk(clk), .resetn(resetn), .ioWr(ioWr),
		.ioRd(ioRd), .ioAddr(ioAddr), .ioWdata(ioWdata), .memWr(memWr), .memRd(memRd),
		.memAddr(memAddr), .memWdata(memWdata), .engineBusy(engineBusy),
		.engineRdata(engineRdata), .dacWrReq(dacWrReq), .dacWrIdx(dacWrIdx),
		.rdValid(rdValid), .rdData(rdData), .enhWr(enhWr), .enhRd(enhRd), .enhAddr(enhAddr),
		.enhData(enhData), .enhMem(enhMem), .dispWr(dispWr), .dispRd(dispRd),
		.dispAddr(dispAddr), .dispData(dispData), .dispVgaMap(dispVgaMap),
		.wrPosted(wrPosted), .advFuncEn(advFuncEn), .cursorEn(cursorEn),
		.cursorExt(cursorExt), .crtTranslate(crtTranslate), .dacWrGrant(dacWrGrant),
		.intEnable(intEnable), .subsysEn(subsysEn));
	emh_engine_model i_eng (.enhRd(enhRd), .enhAddr(enhAddr), .engineRdata(engineRdata));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic iow(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		#1 ioWr = 1'b1;
		ioAddr = a;
		ioWdata = d;
		@(posedge clk);
		#1 ioWr = 1'b0;
	endtask
	task automatic ior(input logic [15:0] a);
		@(posedge clk);
		#1 ioRd = 1'b1;
		ioAddr = a;
		@(posedge clk);
		#1 ioRd = 1'b0;
	endtask
	task automatic crw(input logic [7:0] ix, input logic [7:0] d);
		iow(IO_CRTC_IX, {8'h00, ix});
		iow(IO_CRTC_DAT, {8'h00, d});
	endtask
	task automatic memw(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk);
		#1 memWr = 1'b1;
		memAddr = a;
		memWdata = d;
		@(posedge clk);
		#1 memWr = 1'b0;
	endtask
	task automatic dac(input logic [7:0] i);
		@(posedge clk);
		#1 dacWrReq = 1'b1;
		dacWrIdx = i;
		@(posedge clk);
		#1 dacWrReq = 1'b0;
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#100us;
		n_errors++;
		wrap_up();
	end
	initial begin
		{resetn, ioWr, ioRd, memWr, memRd, engineBusy, dacWrReq} = '0;
		{ioAddr, ioWdata, memWdata, memAddr, dacWrIdx} = '0;
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		`CHK({advFuncEn, rdValid, enhWr, intEnable}, 7'h00)
		tdone("reset");
		crw(IX_LOCK1, 8'h48);
		crw(IX_LOCK2, 8'h40);
		crw(IX_SYSCFG, 8'h01);
		iow(IO_AFC, 16'h0001);
		`CHK(enhWr, 1'b0)
		crw(IX_LOCK2, 8'ha0);
		iow(IO_AFC, 16'h0001);
		`CHK(enhWr, 1'b0)
		crw(IX_SYSCFG, 8'h01);
		iow(IO_AFC, 16'h0001);
		`CHK(enhAddr, IO_AFC)
		`CHK(advFuncEn, 1'b1)
		ior(IO_AFC);
		`CHK(rdData, 16'h0001)
		tdone("unlock");
		foreach (rows[i]) begin
			crw(IX_EXTMODE, rows[i].r ? 8'h10 : 8'h00);
			iow(rows[i].a, ~rows[i].a);
			`CHK(enhWr, rows[i].h)
			`CHK(wrPosted, rows[i].h)
			if (rows[i].h) begin
				`CHK(enhAddr, rows[i].c)
				`CHK(enhData, ~rows[i].a)
			end
		end
		iow(IO_SETUP, 16'h0008);
		`CHK(subsysEn, 1'b1)
		iow(16'h4948, 16'h0001);
		`CHK(enhAddr, IO_AFC)
		iow(IO_AFC, 16'h0001);
		`CHK(enhWr, 1'b0)
		crw(IX_EXTMODE, 8'h00);
		tdone("decode");
		iow(IO_SUBSYS, 16'h0a00);
		`CHK(intEnable, 4'ha)
		iow(IO_SUBSYS, 16'h0500);
		`CHK(intEnable, 4'h5)
		crw(IX_CURSOR, 8'h01);
		`CHK(cursorEn, 1'b1)
		crw(IX_DACCTL, 8'h20);
		`CHK(cursorExt, 1'b1)
		tdone("modes");
		engineBusy = 1'b1;
		ior(IO_STATUS);
		`CHK(rdValid, 1'b1)
		`CHK(rdData, 16'h0200)
		engineBusy = 1'b0;
		ior(IO_PIX_LO);
		`CHK(enhRd, 1'b1)
		@(posedge clk);
		#1 `CHK(rdData, ~IO_PIX_LO)
		tdone("reads");
		memw(32'h000a_0002, 16'h1234);
		`CHK(enhWr, 1'b0)
		iow(IO_AFC, 16'h0021);
		memw(32'h000a_0002, 16'h1234);
		`CHK(enhAddr, IO_PIX_HI)
		`CHK(enhMem, 1'b1)
		iow(IO_AFC, 16'h0001);
		crw(IX_EXTMEM, 8'h10);
		memw(32'h000a_8ae8, 16'h5555);
		`CHK(enhAddr, 16'h8ae8)
		memw(32'h000a_bee8, 16'hf000);
		`CHK(enhWr, 1'b0)
		crw(IX_EXTMEM, 8'h00);
		tdone("mmio");
		memw(32'h000a_1234, 16'h0001);
		`CHK(wrPosted, 1'b0)
		`CHK(dispVgaMap, 1'b1)
		`CHK(dispWr, 1'b1)
		`CHK(dispData, 16'h0001)
		crw(IX_SYSCFG, 8'h09);
		memw(32'h000a_1234, 16'h0001);
		`CHK(wrPosted, 1'b1)
		crw(IX_MEMCFG, 8'h08);
		memw(32'h000a_1234, 16'h0001);
		`CHK(dispAddr, 22'h00_1234)
		crw(IX_CRTLOCK, 8'h05);
		crw(IX_EXTSYS2, 8'h0c);
		crw(IX_MEMCFG, 8'h09);
		memw(32'h000a_1234, 16'h0001);
		`CHK(dispAddr, 22'h35_1234)
		crw(IX_MISC1, 8'h08);
		memw(32'h000b_2000, 16'h0001);
		`CHK(dispAddr, 22'h3f_2000)
		memw(32'h000b_1000, 16'h0001);
		`CHK(dispAddr, 22'h3f_9000)
		crw(IX_LINPOSH, 8'h04);
		crw(IX_LINCTL, 8'h10);
		memw(32'h0400_0100, 16'h0001);
		`CHK(dispAddr, 22'h00_0100)
		@(posedge clk);
		#1 memRd = 1'b1;
		@(posedge clk);
		#1 memRd = 1'b0;
		`CHK(dispRd, 1'b1)
		tdone("memory");
		crw(IX_COMPAT1, 8'h08);
		`CHK(crtTranslate, 1'b1)
		dac(8'h3f);
		`CHK(dacWrGrant, 1'b1)
		dac(8'h40);
		`CHK(dacWrGrant, 1'b0)
		crw(IX_COMPAT2, 8'h10);
		dac(8'h00);
		`CHK(dacWrGrant, 1'b0)
		crw(IX_LOCK2, 8'h20);
		crw(IX_CURSOR, 8'h00);
		`CHK(cursorEn, 1'b1)
		tdone("legacy");
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> emh_engine_model.sv
// drawing engine stand-in answering engine reads
`timescale 1ns/1ps
`default_nettype none
module emh_engine_model (
	input  wire logic        enhRd,       // engine read strobe
	input  wire logic [15:0] enhAddr,     // canonical port
	output logic      [15:0] engineRdata  // engine data
);
	// inside a read cycle show the inverse so stale data never matches
	assign engineRdata = enhRd ? ~enhAddr : enhAddr;
endmodule
`default_nettype wire

// >>> emh_io_decode.sv
// port decoder for the enhanced register families, matching their low ten bits
`timescale 1ns/1ps
`default_nettype none
module emh_io_decode (
	emh_dec_if.dec d // decoder side
);
	import emh_pkg::*;
	logic [15:0] canon;

	// undo the remap so one compare serves both maps
	assign canon = d.remap ? (d.ioAddr ^ IO_REMAP_XOR) : d.ioAddr;
	assign d.canon = canon;
	// setup port is outside the families and never moves
	assign d.setupHit = (d.ioAddr == IO_SETUP);
	// when remapped the default ports no longer land on ENH_LOW
	assign d.enhHit = (canon[9:0] == ENH_LOW) && (canon != IO_SETUP);
	assign d.crtcIxHit = (d.ioAddr == IO_CRTC_IX);
	assign d.crtcDatHit = (d.ioAddr == IO_CRTC_DAT);
endmodule
`default_nettype wire

// >>> emh_pkg.sv
// constants and register map for the enhanced mode host decoder
// Summary of operation
// - enhanced group locked until config bit 0
// - advanced functions run only while control bit 0
// - default ports at x2E8, x6E8, xAE8, xEE8
// - remap bit moves ports by XOR 3A0
// - setup port address never remapped
// - low ten address bits compared for the families
// - memory mapping enabled by either enable bit
// - A0000-A7FFF memory access is pixel transfer
// - A8xE8-ABxE8 writes reach command registers
// - read selector never reachable through memory
// - shared text goes to top 32K/64K
// - each interrupt source enabled independently
// - commands always posted, others by config bit 3
// - cursor shown only while cursor bit 0
// - external cursor mode feeds the DAC
// - linear window enabled by either bit 4
// - 64K window bank offset added when enabled
// - window bit selects linear or VGA mapping
// - legacy bit selects timing translation
// - palette lock blocks all DAC writes, legacy allows 64 entries
// - system groups unlock on 101xxxxx only
package emh_pkg;
	localparam int          IO_AW         = 16;
	localparam int          HA_W          = 32;
	localparam logic [15:0] IO_SUBSYS     = 16'h42e8;
	localparam logic [15:0] IO_SETUP      = 16'h46e8;
	localparam logic [15:0] IO_AFC        = 16'h4ae8;
	localparam logic [15:0] IO_STATUS     = 16'h9ae8;
	localparam logic [15:0] IO_MFC        = 16'hbee8;
	localparam logic [15:0] IO_PIX_LO     = 16'he2e8;
	localparam logic [15:0] IO_PIX_HI     = 16'he2ea;
	localparam logic [15:0] IO_CRTC_IX    = 16'h03d4;
	localparam logic [15:0] IO_CRTC_DAT   = 16'h03d5;
	localparam logic [15:0] IO_REMAP_XOR  = 16'h03a0;
	localparam logic [9:0]  ENH_LOW       = 10'h2e8;
	localparam logic [3:0]  MFC_RDSEL     = 4'hf;
	localparam logic [7:0]  IX_MEMCFG     = 8'h31;
	localparam logic [7:0]  IX_COMPAT1    = 8'h32;
	localparam logic [7:0]  IX_COMPAT2    = 8'h33;
	localparam logic [7:0]  IX_CRTLOCK    = 8'h35;
	localparam logic [7:0]  IX_LOCK1      = 8'h38;
	localparam logic [7:0]  IX_LOCK2      = 8'h39;
	localparam logic [7:0]  IX_MISC1      = 8'h3a;
	localparam logic [7:0]  IX_SYSCFG     = 8'h40;
	localparam logic [7:0]  IX_EXTMODE    = 8'h43;
	localparam logic [7:0]  IX_CURSOR     = 8'h45;
	localparam logic [7:0]  IX_EXTSYS2    = 8'h51;
	localparam logic [7:0]  IX_EXTMEM     = 8'h53;
	localparam logic [7:0]  IX_DACCTL     = 8'h55;
	localparam logic [7:0]  IX_LINCTL     = 8'h58;
	localparam logic [7:0]  IX_LINPOSH    = 8'h59;
	localparam logic [7:0]  IX_LINPOSL    = 8'h5a;
	localparam logic [7:0]  IX_VGAX_LO    = 8'h30;
	localparam logic [7:0]  IX_SYS_LO     = 8'h40;
	localparam logic [7:0]  LOCK1_MASK    = 8'hcc;
	localparam logic [7:0]  LOCK1_KEY     = 8'h48;
	localparam logic [7:0]  LOCK2_MASK    = 8'he0;
	localparam logic [7:0]  LOCK2_KEY     = 8'ha0;
	localparam logic [7:0]  LEGACY_DAC    = 8'h40;
	localparam logic [7:0]  RST_REG       = 8'h00;
	localparam logic [16:0] MEM_PIX_SEG   = 17'h0_0014;
	localparam logic [16:0] MEM_CMD_SEG   = 17'h0_0015;
	localparam logic [15:0] MEM_A_SEG     = 16'h000a;
	localparam logic [15:0] MEM_B_SEG     = 16'h000b;
	localparam logic [3:0]  CMD_NIB_LO    = 4'h8;
	localparam logic [3:0]  CMD_NIB_HI    = 4'hb;
	localparam logic [7:0]  CMD_LOW       = 8'he8;
	localparam int          B_ENH_UNLOCK  = 0;
	localparam int          B_POST        = 3;
	localparam int          B_REMAP       = 4;
	localparam int          B_TEXT        = 3;
	localparam int          B_MMIO_EXT    = 4;
	localparam int          B_AFC_EN      = 0;
	localparam int          B_AFC_LIN     = 4;
	localparam int          B_AFC_MMIO    = 5;
	localparam int          B_CUR_EN      = 0;
	localparam int          B_CUR_EXT     = 5;
	localparam int          B_LIN_EN      = 4;
	localparam int          B_WIN64       = 3;
	localparam int          B_BANK_ADD    = 0;
	localparam int          B_LEGACY      = 3;
	localparam int          B_PAL_LOCK    = 4;
	localparam int          B_BUSY        = 9;
	localparam int          B_TEXT_SEL    = 13;
	localparam int          B_SETUP_EN    = 3;
	localparam int          INT_ENA_LSB   = 8;
endpackage
